// File: tdt_pkg.sv
// constants for the triple cpu down-timer block
package tdt_pkg;
  localparam int          NUM_TIMERS      = 3;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 16;
  // word offsets inside one timer's eight-word slot
  localparam logic [2:0]  OFS_COUNT_LO    = 3'h0;
  localparam logic [2:0]  OFS_COUNT_HI    = 3'h1;
  localparam logic [2:0]  OFS_PERIOD_LO   = 3'h2;
  localparam logic [2:0]  OFS_PERIOD_HI   = 3'h3;
  localparam logic [2:0]  OFS_CONTROL     = 3'h4;
  localparam logic [2:0]  OFS_PRESCALE    = 3'h5;
  localparam logic [2:0]  OFS_PRESC_COUNT = 3'h6;
  // shared routing word sits in slot 3, offset 0 (word 0x18)
  localparam logic [1:0]  SLOT_SHARED     = 2'h3;
  localparam logic [2:0]  OFS_ROUTING     = 3'h0;
  // control word fields
  localparam int          CTL_STOP_BIT    = 4;
  localparam int          CTL_RELOAD_BIT  = 5;
  localparam int          CTL_IEN_BIT     = 14;
  localparam int          CTL_FLAG_BIT    = 15;
  // routing word fields
  localparam int          RT_CLKSEL_LSB   = 0;
  localparam int          RT_LINE13_BIT   = 2;
  // reset values
  localparam logic [31:0] RST_COUNT       = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_PERIOD      = 32'hFFFF_FFFF;
  localparam logic [15:0] RST_PRESCALE    = 16'h0000;
  localparam logic        RST_STOP        = 1'b0;
  localparam logic        RST_IEN         = 1'b0;
  localparam logic        RST_LINE13      = 1'b0;
  // timer 2 clock sources
  typedef enum logic [1:0] {
    TDT_SRC_SYSTEM_CLOCK_OUTPUT = 2'h0,
    TDT_SRC_INTERNAL_OSC_ONE    = 2'h1,
    TDT_SRC_INTERNAL_OSC_TWO    = 2'h2,
    TDT_SRC_EXTERNAL_CLOCK      = 2'h3
  } tdt_clk_src_t;
  localparam tdt_clk_src_t RST_CLKSEL     = TDT_SRC_SYSTEM_CLOCK_OUTPUT;
endpackage

// File: tdt_timer_top.sv
// three 32-bit down-timers with prescalers, reload and interrupt routing
// What this block does
// [RULE1] Three identical timers, each a 32-bit down-counter with a software-preset period value.
// [RULE2] Each timer has a 16-bit prescaler in front of its main counter.
// [RULE3] The main counter steps at the cpu clock rate divided by the programmed prescale setting; the code divides by the setting plus one.
// [RULE4] A timer raises its interrupt request when its count reaches zero.
// [RULE5] At zero the counter reloads itself from the 32-bit period and keeps counting on its own.
// [RULE6] Timer 2 drives cpu interrupt line fourteen directly, bypassing the expansion block.
// [RULE7] Timer 2 clocks from system clock output (reset default), oscillator one, oscillator two or an external source.
// [RULE8] Timer 1 is general purpose and its request can be routed to cpu interrupt line thirteen.
// [RULE9] Timer 0 is general purpose and its request goes to the interrupt expansion block.
// [RULE10] All timer registers sit in a 64-word window of 16-bit words, writable with no unlock step; prescaler count words are read-only.
// [RULE11] The register window is reached directly on the cpu memory bus.
// [RULE12] The prescaler counts down from its setting, gives one counter step when it expires, then reloads.
// [RULE13] Each timer keeps a sticky zero flag cleared by software and can be stopped, started and force-reloaded.
module tdt_timer_top
(
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic [tdt_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [tdt_pkg::DATA_W-1:0] mem_wdata,
  input  wire logic                       mem_we,
  input  wire logic                       mem_re,
  output logic      [tdt_pkg::DATA_W-1:0] mem_rdata,
  input  wire logic                       internal_oscillator_one,
  input  wire logic                       internal_oscillator_two,
  input  wire logic                       external_clock_source,
  output logic                            interrupt_expansion_block_req,
  output logic                            cpu_irq_line_thirteen,
  output logic                            cpu_irq_line_fourteen
);
  import tdt_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [1:0] slot, input logic [2:0] ofs);
    hit = (a == {1'b0, slot, ofs});
  endfunction

  // asynchronous clock sources, synchronised then edge detected
  logic [2:0]     sync1_q;
  logic [2:0]     sync1_d;
  logic [2:0]     sync2_q;
  logic [2:0]     sync2_d;
  logic [2:0]     sync3_q;
  logic [2:0]     sync3_d;
  logic [2:0]     src_edge;

  always_comb
  begin
    sync1_d = {external_clock_source, internal_oscillator_two, internal_oscillator_one};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    src_edge = sync2_q & ~sync3_q;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // shared routing word
  tdt_clk_src_t   clksel_q;
  tdt_clk_src_t   clksel_d;
  logic           line13_q;
  logic           line13_d;
  logic           route_wr;

  // [RULE10] unlocked write
  assign route_wr = mem_we && hit(mem_addr, SLOT_SHARED, OFS_ROUTING);

  always_comb
  begin
    clksel_d = clksel_q;
    line13_d = line13_q;
    if (route_wr)
    begin
      clksel_d = tdt_clk_src_t'(mem_wdata[RT_CLKSEL_LSB +: 2]);
      line13_d = mem_wdata[RT_LINE13_BIT];
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clksel_q <= RST_CLKSEL;
      line13_q <= RST_LINE13;
    end
    else
    begin
      clksel_q <= clksel_d;
      line13_q <= line13_d;
    end
  end

  // per-timer source enable; timers 0 and 1 step on the cpu clock
  logic           src_tick [NUM_TIMERS];
  logic [31:0]    cnt_all  [NUM_TIMERS];
  logic [31:0]    per_all  [NUM_TIMERS];
  logic [15:0]    psc_all  [NUM_TIMERS];
  logic [15:0]    pcnt_all [NUM_TIMERS];
  logic [15:0]    ctl_all  [NUM_TIMERS];
  logic           irq_all  [NUM_TIMERS];

  // [RULE7] timer 2 source select
  always_comb
  begin
    src_tick[0] = 1'b1;
    src_tick[1] = 1'b1;
    case (clksel_q)
      TDT_SRC_SYSTEM_CLOCK_OUTPUT: src_tick[2] = 1'b1;
      TDT_SRC_INTERNAL_OSC_ONE:    src_tick[2] = src_edge[0];
      TDT_SRC_INTERNAL_OSC_TWO:    src_tick[2] = src_edge[1];
      TDT_SRC_EXTERNAL_CLOCK:      src_tick[2] = src_edge[2];
      default:                     src_tick[2] = 1'b1;
    endcase
  end

  // [RULE1] three identical timers
  for (genvar t = 0; t < NUM_TIMERS; t++)
  begin : gen_timer
    localparam logic [1:0] SLOT = 2'(t);
    logic [31:0]  cnt_q;
    logic [31:0]  cnt_d;
    logic [31:0]  per_q;
    logic [31:0]  per_d;
    logic [15:0]  psc_q;
    logic [15:0]  psc_d;
    logic [15:0]  pcnt_q;
    logic [15:0]  pcnt_d;
    logic         stop_q;
    logic         stop_d;
    logic         ien_q;
    logic         ien_d;
    logic         flag_q;
    logic         flag_d;
    logic         step;
    logic         zero_set;
    logic         ctl_wr;

    assign ctl_wr = mem_we && hit(mem_addr, SLOT, OFS_CONTROL);

    always_comb
    begin
      cnt_d    = cnt_q;
      per_d    = per_q;
      psc_d    = psc_q;
      pcnt_d   = pcnt_q;
      stop_d   = stop_q;
      ien_d    = ien_q;
      step     = 1'b0;
      zero_set = 1'b0;
      // [RULE2] 16-bit prescaler
      // [RULE12] prescaler expire and reload
      if (!stop_q && src_tick[t])
      begin
        if (pcnt_q == 16'h0000)
        begin
          step   = 1'b1;
          pcnt_d = psc_q;
        end
        else
        begin
          pcnt_d = pcnt_q - 16'h0001;
        end
      end
      // [RULE3] counter steps at divided rate
      if (step)
      begin
        // [RULE5] automatic period reload
        if (cnt_q == 32'h0000_0000)
        begin
          cnt_d    = per_q;
          zero_set = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      // [RULE10] software writes need no unlock
      if (mem_we && hit(mem_addr, SLOT, OFS_COUNT_LO))
        cnt_d[15:0] = mem_wdata;
      if (mem_we && hit(mem_addr, SLOT, OFS_COUNT_HI))
        cnt_d[31:16] = mem_wdata;
      if (mem_we && hit(mem_addr, SLOT, OFS_PERIOD_LO))
        per_d[15:0] = mem_wdata;
      if (mem_we && hit(mem_addr, SLOT, OFS_PERIOD_HI))
        per_d[31:16] = mem_wdata;
      if (mem_we && hit(mem_addr, SLOT, OFS_PRESCALE))
        psc_d = mem_wdata;
      // [RULE13] stop, start and forced reload
      if (ctl_wr)
      begin
        stop_d = mem_wdata[CTL_STOP_BIT];
        ien_d  = mem_wdata[CTL_IEN_BIT];
        if (mem_wdata[CTL_RELOAD_BIT])
        begin
          cnt_d  = per_d;
          pcnt_d = psc_d;
        end
      end
      // [RULE13] sticky flag, a new zero beats the clear
      flag_d = (flag_q & ~(ctl_wr & mem_wdata[CTL_FLAG_BIT])) | zero_set;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
      begin
        cnt_q  <= RST_COUNT;
        per_q  <= RST_PERIOD;
        psc_q  <= RST_PRESCALE;
        pcnt_q <= RST_PRESCALE;
        stop_q <= RST_STOP;
        ien_q  <= RST_IEN;
        flag_q <= 1'b0;
      end
      else
      begin
        cnt_q  <= cnt_d;
        per_q  <= per_d;
        psc_q  <= psc_d;
        pcnt_q <= pcnt_d;
        stop_q <= stop_d;
        ien_q  <= ien_d;
        flag_q <= flag_d;
      end
    end

    assign cnt_all[t]  = cnt_q;
    assign per_all[t]  = per_q;
    assign psc_all[t]  = psc_q;
    assign pcnt_all[t] = pcnt_q;
    // [RULE4] request follows the zero flag
    assign irq_all[t]  = flag_q & ien_q;
    always_comb
    begin
      ctl_all[t] = 16'h0000;
      ctl_all[t][CTL_STOP_BIT] = stop_q;
      ctl_all[t][CTL_IEN_BIT]  = ien_q;
      ctl_all[t][CTL_FLAG_BIT] = flag_q;
    end
  end

  // [RULE11] memory bus read, one cycle latency
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              irq0_q;
  logic              irq0_d;
  logic              irq13_q;
  logic              irq13_d;
  logic              irq14_q;
  logic              irq14_d;

  always_comb
  begin
    rdata_d = rdata_q;
    if (mem_re)
    begin
      rdata_d = 16'h0000;
      for (int t = 0; t < NUM_TIMERS; t++)
      begin
        if (hit(mem_addr, 2'(t), OFS_COUNT_LO))
          rdata_d = cnt_all[t][15:0];
        if (hit(mem_addr, 2'(t), OFS_COUNT_HI))
          rdata_d = cnt_all[t][31:16];
        if (hit(mem_addr, 2'(t), OFS_PERIOD_LO))
          rdata_d = per_all[t][15:0];
        if (hit(mem_addr, 2'(t), OFS_PERIOD_HI))
          rdata_d = per_all[t][31:16];
        if (hit(mem_addr, 2'(t), OFS_CONTROL))
          rdata_d = ctl_all[t];
        if (hit(mem_addr, 2'(t), OFS_PRESCALE))
          rdata_d = psc_all[t];
        if (hit(mem_addr, 2'(t), OFS_PRESC_COUNT))
          rdata_d = pcnt_all[t];
      end
      if (hit(mem_addr, SLOT_SHARED, OFS_ROUTING))
      begin
        rdata_d[RT_CLKSEL_LSB +: 2] = clksel_q;
        rdata_d[RT_LINE13_BIT]      = line13_q;
      end
    end
    // [RULE9] timer 0 to the expansion block
    irq0_d  = irq_all[0];
    // [RULE8] timer 1 routable to line thirteen
    irq13_d = irq_all[1] & line13_q;
    // [RULE6] timer 2 straight to line fourteen
    irq14_d = irq_all[2];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= 16'h0000;
      irq0_q  <= 1'b0;
      irq13_q <= 1'b0;
      irq14_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq0_q  <= irq0_d;
      irq13_q <= irq13_d;
      irq14_q <= irq14_d;
    end
  end

  assign mem_rdata                     = rdata_q;
  assign interrupt_expansion_block_req = irq0_q;
  assign cpu_irq_line_thirteen         = irq13_q;
  assign cpu_irq_line_fourteen         = irq14_q;

endmodule

// File: tdt_assertions.sv
// port-level assertions for the triple down-timer
module tdt_checker
(
  input wire logic                       clock,
  input wire logic                       arst_n,
  input wire logic [tdt_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [tdt_pkg::DATA_W-1:0] mem_wdata,
  input wire logic                       mem_we,
  input wire logic                       mem_re,
  input wire logic [tdt_pkg::DATA_W-1:0] mem_rdata,
  input wire logic                       interrupt_expansion_block_req,
  input wire logic                       cpu_irq_line_thirteen,
  input wire logic                       cpu_irq_line_fourteen
);
  import tdt_pkg::*;
  logic route_d;
  logic route_q;
  logic w0;
  logic w1;
  logic w2;
  assign w0 = mem_we && mem_addr == 6'h04;
  assign w1 = mem_we && mem_addr == 6'h0C;
  assign w2 = mem_we && mem_addr == 6'h14;
  // shadow of the line 13 route bit, seen from the bus side
  always_comb
  begin
    route_d = route_q;
    if (mem_we && mem_addr == 6'h18)
      route_d = mem_wdata[RT_LINE13_BIT];
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      route_q <= 1'b0;
    else
      route_q <= route_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_unmapped_reads_zero: assert property (mem_re && (mem_addr[2:0] == 3'h7 || mem_addr > 6'h18)
    |=> mem_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!mem_re |=> $stable(mem_rdata)) else $error("read data moved");
  a_t0_ien_off: assert property (w0 && !mem_wdata[CTL_IEN_BIT] |-> ##2 !interrupt_expansion_block_req)
    else $error("timer 0 request not gated");
  a_t1_ien_off: assert property (w1 && !mem_wdata[CTL_IEN_BIT] |-> ##2 !cpu_irq_line_thirteen)
    else $error("timer 1 request not gated");
  a_t2_ien_off: assert property (w2 && !mem_wdata[CTL_IEN_BIT] |-> ##2 !cpu_irq_line_fourteen)
    else $error("timer 2 request not gated");
  a_line13_route: assert property (!route_q && $past(!route_q) |-> !cpu_irq_line_thirteen)
    else $error("line 13 without route");
  a_t2_sticky: assert property (cpu_irq_line_fourteen && !w2 && !$past(w2) |=> cpu_irq_line_fourteen)
    else $error("timer 2 request dropped");
  a_t0_sticky: assert property (interrupt_expansion_block_req && !w0 && !$past(w0)
    |=> interrupt_expansion_block_req) else $error("timer 0 request dropped");
endmodule
bind tdt_timer_top tdt_checker i_chk (.clock, .arst_n, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
  .interrupt_expansion_block_req, .cpu_irq_line_thirteen, .cpu_irq_line_fourteen);

// File: tdt_far_side.sv
// far side model: timer 2 clock sources and a line 13 watcher
module tdt_far_side (
  input  wire logic clock,
  input  wire logic cpu_irq_line_thirteen,
  output logic      internal_oscillator_one = 1'b0,
  output logic      internal_oscillator_two = 1'b0,
  output logic      external_clock_source = 1'b0,
  output int        n_line13 = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  int   div = 0;
  logic l13_q = 1'b0;
  // three slow sources
  // whole fractions of the clock, so a 60-cycle window holds an exact tick count
  always @(negedge clock)
  begin
    div <= (div + 1) % 60;
    internal_oscillator_one <= (div % 4) < 2;
    internal_oscillator_two <= (div % 6) < 3;
    external_clock_source <= (div % 10) < 5;
  end
  always @(posedge clock)
  begin
    l13_q <= cpu_irq_line_thirteen;
    if (cpu_irq_line_thirteen && !l13_q)
      n_line13 <= n_line13 + 1;
  end
endmodule

// File: tb_top.sv
// self-checking bench for the triple down-timer
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tdt_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        mem_we = 1'b0;
  logic        mem_re = 1'b0;
  logic [5:0]  mem_addr = 6'h00;
  logic [15:0] mem_wdata = 16'h0000;
  logic [15:0] mem_rdata;
  logic [15:0] v;
  logic [15:0] w;
  logic        o1;
  logic        o2;
  logic        ext;
  wire [2:0]   irqs;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n13;
  tdt_timer_top i_dut (.clock, .arst_n, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
    .internal_oscillator_one(o1), .internal_oscillator_two(o2), .external_clock_source(ext),
    .interrupt_expansion_block_req(irqs[0]), .cpu_irq_line_thirteen(irqs[1]), .cpu_irq_line_fourteen(irqs[2]));
  tdt_far_side i_far (.clock, .cpu_irq_line_thirteen(irqs[1]), .internal_oscillator_one(o1),
    .internal_oscillator_two(o2), .external_clock_source(ext), .n_line13(n13));
  initial
  begin
    forever #20 clock = ~clock;
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clock);
    mem_addr = a;
    mem_wdata = d;
    mem_we = 1'b1;
    @(negedge clock);
    mem_we = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clock);
    mem_addr = a;
    mem_re = 1'b1;
    @(negedge clock);
    mem_re = 1'b0;
    d = mem_rdata;
  endtask
  task automatic wait_irq(input int i, input logic lvl);
    int n = 0;
    while (irqs[i] !== lvl && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    `CHK("irq level", lvl, irqs[i])
  endtask
  task automatic t_reset;
    logic [5:0]  a[5] = '{6'h02, 6'h0B, 6'h15, 6'h18, 6'h3F};
    logic [15:0] e[5] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++)
    begin
      rd(a[i], v);
      `CHK("reset word", e[i], v)
    end
    wr(6'h0A, 16'h1234);
    rd(6'h0A, v);
    `CHK("period write", 16'h1234, v)
    $display("t_reset done");
  endtask
  task automatic t_period;
    time t0;
    wr(6'h12, 16'h0003);
    wr(6'h13, 16'h0000);
    wr(6'h15, 16'h0001);
    wr(6'h14, 16'h4020);
    wait_irq(2, 1'b1);
    t0 = $time;
    wr(6'h14, 16'hC000);
    wait_irq(2, 1'b0);
    wait_irq(2, 1'b1);
    // two clocks a step, four steps a period
    `CHK("t2 spacing", 64'd8, ($time - t0) / 40)
    wr(6'h14, 16'h8010);
    $display("t_period done");
  endtask
  task automatic t_zero_flag;
    wr(6'h02, 16'h0000);
    wr(6'h03, 16'h0000);
    wr(6'h04, 16'h4020);
    wait_irq(0, 1'b1);
    rd(6'h04, v);
    `CHK("flag set", 1'b1, v[CTL_FLAG_BIT])
    // stop first: with period 0 a zero event lands every cycle and beats a clear
    wr(6'h04, 16'h0010);
    wr(6'h04, 16'h8010);
    rd(6'h04, v);
    `CHK("flag clear", 1'b0, v[CTL_FLAG_BIT])
    `CHK("t0 req off", 1'b0, irqs[0])
    wr(6'h00, 16'h0040);
    rd(6'h00, v);
    repeat (5) @(negedge clock);
    rd(6'h00, w);
    `CHK("stopped count", v, w)
    `CHK("count held", 16'h0040, w)
    $display("t_zero_flag done");
  endtask
  task automatic t_route;
    wr(6'h0A, 16'h0000);
    wr(6'h0B, 16'h0000);
    wr(6'h0C, 16'h4020);
    repeat (10) @(negedge clock);
    `CHK("line13 unrouted", 1'b0, irqs[1])
    wr(6'h18, 16'h0004);
    wait_irq(1, 1'b1);
    repeat (2) @(negedge clock);
    `CHK("line13 rises", 1, n13)
    wr(6'h18, 16'h0000);
    wr(6'h0C, 16'h8010);
    $display("t_route done");
  endtask
  task automatic t_sources;
    int tk[4] = '{60, 15, 10, 6};
    wr(6'h12, 16'hFFFF);
    wr(6'h13, 16'hFFFF);
    wr(6'h15, 16'h0000);
    wr(6'h14, 16'h0020);
    for (int s = 0; s < 4; s++)
    begin
      wr(6'h18, 16'(s));
      repeat (4) @(negedge clock);
      rd(6'h10, v);
      repeat (58) @(negedge clock);
      rd(6'h10, w);
      `CHK("t2 ticks", 16'(tk[s]), v - w)
    end
    $display("t_sources done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    $display("[ERR] run state exp done got timeout");
    test_done;
  end
  initial
  begin
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    t_reset;
    t_period;
    t_zero_flag;
    t_route;
    t_sources;
    test_done;
  end
endmodule
